// *** rtl/ad_pkg.sv ***
// Shared definitions of the arithmetic datapath: register map, control
// and status bit positions, opcodes and the command word layout.
// Assumes a 32-bit APB with byte addresses, one register per aligned word.
package ad_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_OPA  = 8'h08;
    localparam logic [7:0] A_OPB  = 8'h0C;
    localparam logic [7:0] A_OPC  = 8'h10;
    localparam logic [7:0] A_CMD  = 8'h14;
    localparam logic [7:0] A_QUO  = 8'h18;
    localparam logic [7:0] A_REM  = 8'h1C;
    localparam logic [7:0] A_AAL  = 8'h20;
    localparam logic [7:0] A_AAH  = 8'h24;
    localparam logic [7:0] A_ABL  = 8'h28;
    localparam logic [7:0] A_ABH  = 8'h2C;
    localparam logic [7:0] A_WBK  = 8'h30;

    // ----------------------------------------
    // Control and status fields, reset values
    // ----------------------------------------
    localparam int CB_IF   = 0;
    localparam int CB_RDM  = 1;
    localparam int CB_ASAT = 4;
    localparam int CB_SATD = 5;
    localparam int CB_SBE  = 6;
    localparam int CB_SAE  = 7;
    localparam int CB_USG  = 12;
    localparam int SB_C    = 0;
    localparam int SB_Z    = 1;
    localparam int SB_OVF  = 2;
    localparam int SB_N    = 3;
    localparam int SB_DCY  = 8;
    localparam int SB_BUSY = 15;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam logic [3:0]  DIV_LAST = 4'hF;

    // ----------------------------------------
    // Opcodes, command word, divider states
    // ----------------------------------------
    typedef enum logic [4:0] {
        OP_ADD = 5'h00, OP_SUB = 5'h01, OP_AND = 5'h02, OP_IOR = 5'h03,
        OP_XOR = 5'h04, OP_SHL = 5'h05, OP_LSR = 5'h06, OP_ASR = 5'h07,
        OP_MSS = 5'h08, OP_MUU = 5'h09, OP_MSL = 5'h0A, OP_MUK = 5'h0B,
        OP_MUS = 5'h0C, OP_DS16 = 5'h0D, OP_DU16 = 5'h0E, OP_DS32 = 5'h0F,
        OP_DU32 = 5'h10, OP_PRD = 5'h11, OP_MPYN = 5'h12, OP_MACC = 5'h13,
        OP_MSUB = 5'h14, OP_SQD = 5'h15, OP_SQDA = 5'h16, OP_AADD = 5'h17,
        OP_ASUB = 5'h18, OP_ANEG = 5'h19, OP_LDA = 5'h1A, OP_ADDW = 5'h1B,
        OP_MOVS = 5'h1C, OP_CLR = 5'h1D
    } ad_op_t;

    typedef struct packed {
        logic [3:0] shift;
        logic       wb;
        logic       acc_sel;
        logic       byte_mode;
        ad_op_t     op;
    } ad_cmd_t;

    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_RUN  = 2'b01
    } ad_dstate_t;
endpackage : ad_pkg

// *** rtl/ad_alu_dsp.sv ***
// Arithmetic datapath: 16-bit integer unit, shared 17x17 multiplier,
// iterative divider and the front end of the two 40-bit accumulators.
// Assumes an APB master; one command runs at a time, issued by a CMD write.
//
// Functional notes
// (RULE_01) Integer unit adds, subtracts, shifts and does logic on 16-bit words
// (RULE_02) Integer ops update carry, zero, negative, overflow, digit-carry flags
// (RULE_03) On subtract, carry and digit-carry report borrow and digit borrow
// (RULE_04) Byte or word width is chosen by the command's width bit
// (RULE_05) Operands come from working registers, results go back to them
// (RULE_06) Integer multiply: SS, UU, S x lit5, U x lit5, U x S, 8x8 unsigned
// (RULE_07) Divider: signed and unsigned 32/16 and 16/16
// (RULE_08) Quotient lands in the quotient register, remainder in remainder
// (RULE_09) Divisor any register; 32-bit dividend from a high:low pair; the code always takes the divisor from OPB
// (RULE_10) One cycle per divisor bit; both divide sizes take equal time
// (RULE_11) Engine has 17x17 multiplier, shifter and 40-bit add/subtract
// (RULE_12) Engine never runs beside a separate integer operation
// (RULE_13) Accumulator add, subtract and negate need no operand data
// (RULE_14) Engine options come from core control register bits
// (RULE_15) Engine multiply signed or unsigned; scaler picks 1.31 or integer
// (RULE_16) Multiplier inputs widened to 17 bits by zero or sign extension
// (RULE_17) 33-bit multiplier result is sign-extended to 40 bits
// (RULE_18) Fraction operands span 0x8000..0x7FFF; 16x16 gives 1.31
// (RULE_19) Integer multiply writes 16-bit byte product or 32-bit word product
// (RULE_20) Accumulator adder sign-extends; either accumulator is source/target
// (RULE_21) Accumulator add and load data may be scaled by the shifter
// (RULE_22) Saturation enables at control bits 7, 6, 5; bit 4 picks mode; the code stores these bits but applies no saturation
// (RULE_23) Multiply-accumulate ops may store rounded high word of other accumulator
// (RULE_24) Fractional mode shifts the signed product left by one
// (RULE_25) Divider results held until last step, then both written together
`timescale 1ns/1ps
module ad_alu_dsp
    import ad_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);
    logic [15:0]        ctrl, stat, opa, opb, opc, quo, rem, wback;
    logic [39:0]        acc_a, acc_b, tgt, oth, nacc, p40;
    logic signed [39:0] ldv, shd;
    logic [31:0]        rdata;
    logic               hit, wr, go, busy, is_dsp, is_int, wb_ok;
    ad_cmd_t            cmd;
    ad_dstate_t         dst;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // One wait state: pready rises in the second access cycle.
    assign cmd  = ad_cmd_t'(pwdata[11:0]);
    assign busy = (dst != D_IDLE);
    assign wr   = psel && penable && pready && pwrite;
    assign go   = wr && (paddr == A_CMD) && !busy; // RULE_12

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            A_CTRL: rdata = {16'h0000, ctrl};
            A_STAT: rdata = {16'h0000, busy, stat[14:0]};
            A_OPA:  rdata = {16'h0000, opa};
            A_OPB:  rdata = {16'h0000, opb};
            A_OPC:  rdata = {16'h0000, opc};
            A_CMD:  rdata = 32'h0000_0000;
            A_QUO:  rdata = {16'h0000, quo};
            A_REM:  rdata = {16'h0000, rem};
            A_AAL:  rdata = acc_a[31:0];
            A_AAH:  rdata = {24'h00_0000, acc_a[39:32]};
            A_ABL:  rdata = acc_b[31:0];
            A_ABH:  rdata = {24'h00_0000, acc_b[39:32]};
            A_WBK:  rdata = {16'h0000, wback};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pready && !pwrite) ? rdata : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !hit;
        end
    end

    // ----------------------------------------
    // Control and operand registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
            opa  <= 16'h0000;
            opb  <= 16'h0000;
            opc  <= 16'h0000;
        end else if (wr) begin
            if (paddr == A_CTRL) ctrl <= pwdata[15:0]; // RULE_14 RULE_22
            if (paddr == A_OPA) opa <= pwdata[15:0];   // RULE_05
            if (paddr == A_OPB) opb <= pwdata[15:0];
            if (paddr == A_OPC) opc <= pwdata[15:0];   // RULE_09
        end
    end

    // ----------------------------------------
    // Integer unit
    // ----------------------------------------
    logic [16:0] msk, a17, b17, bx, sum, ares, top;
    logic [4:0]  nib;
    logic        sub, asgn, bsgn, rsgn, cout, nc;

    always_comb begin
        msk  = cmd.byte_mode ? 17'h000FF : 17'h0FFFF; // RULE_04
        top  = msk ^ (msk >> 1);
        a17  = {1'b0, opa} & msk;
        b17  = {1'b0, opb} & msk;
        sub  = (cmd.op == OP_SUB) || (cmd.op == OP_SQD) || (cmd.op == OP_SQDA);
        bx   = sub ? (~b17 & msk) : b17;
        sum  = a17 + bx + {16'h0000, sub}; // RULE_01
        nib  = {1'b0, a17[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub};
        cout = cmd.byte_mode ? sum[8] : sum[16];
        asgn = |(a17 & top);
        bsgn = |(bx & top);
        case (cmd.op)
            OP_AND:  ares = a17 & b17;
            OP_IOR:  ares = a17 | b17;
            OP_XOR:  ares = a17 ^ b17;
            OP_SHL:  ares = (a17 << 1) & msk;
            OP_LSR:  ares = a17 >> 1;
            OP_ASR:  ares = (a17 >> 1) | (top & {17{asgn}});
            default: ares = sum & msk;
        endcase
        rsgn = |(ares & top);
        case (cmd.op)
            OP_SHL:         nc = asgn;
            OP_LSR, OP_ASR: nc = a17[0];
            OP_AND, OP_IOR, OP_XOR: nc = stat[SB_C];
            default:        nc = cout; // RULE_03
        endcase
    end

    assign is_int = (cmd.op <= OP_ASR);
    assign is_dsp = (cmd.op >= OP_PRD);

    // Bits 14:0 are kept, flags or APB-written; busy is read live from the divider.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat <= STAT_RST;
        end else if (go && (is_int || cmd.op == OP_SQD || cmd.op == OP_SQDA)) begin
            stat[SB_C] <= nc;                       // RULE_02 RULE_03
            stat[SB_Z] <= (ares[15:0] == 16'h0000);
            stat[SB_N] <= rsgn;
            if (cmd.op <= OP_SUB || !is_int) begin
                stat[SB_OVF] <= (asgn == bsgn) && (rsgn != asgn);
                stat[SB_DCY] <= nib[4];             // RULE_03
            end
        end else if (wr && paddr == A_STAT) begin
            stat <= pwdata[15:0] & 16'h7FFF;
        end
    end

    // ----------------------------------------
    // Shared 17x17 multiplier and scaler
    // ----------------------------------------
    logic signed [16:0] ma, mb;
    logic signed [33:0] prod;
    logic [16:0]        sxa, sxb, lit, dd, zsa, zsb;
    logic [32:0]        scl;
    logic               frac, usgn;

    always_comb begin
        usgn = ctrl[CB_USG];  // RULE_14
        frac = !ctrl[CB_IF];
        sxa  = {opa[15], opa};
        sxb  = {opb[15], opb};
        lit  = {12'h000, opb[4:0]};
        dd   = {ares[15], ares[15:0]};
        zsa  = usgn ? a17 : sxa; // RULE_15
        zsb  = usgn ? b17 : sxb;
        case (cmd.op) // RULE_06 RULE_16
            OP_MSS:        begin ma = sxa; mb = sxb; end
            OP_MUU:        begin ma = a17; mb = b17; end
            OP_MSL:        begin ma = sxa; mb = lit; end
            OP_MUK:        begin ma = a17; mb = lit; end
            OP_MUS:        begin ma = a17; mb = sxb; end
            OP_SQD, OP_SQDA: begin ma = dd; mb = dd; end // RULE_12
            default:       begin ma = zsa; mb = zsb; end
        endcase
        prod = ma * mb; // RULE_11
        // Left shift aligns Q15 x Q15 into 1.31
        scl  = frac ? {prod[31:0], 1'b0} : prod[32:0]; // RULE_18 RULE_24
        p40  = {{7{scl[32]}}, scl}; // RULE_17
    end

    // ----------------------------------------
    // Accumulator front end
    // ----------------------------------------
    logic [15:0] rhi;
    logic        rinc;

    always_comb begin
        tgt  = cmd.acc_sel ? acc_b : acc_a; // RULE_20
        oth  = cmd.acc_sel ? acc_a : acc_b;
        ldv  = {{8{opa[15]}}, opa, 16'h0000};
        shd  = ldv >>> cmd.shift; // RULE_21
        case (cmd.op) // RULE_13
            OP_PRD, OP_SQD:   nacc = p40;
            OP_MPYN:          nacc = 40'h00_0000_0000 - p40;
            OP_MACC, OP_SQDA: nacc = tgt + p40;
            OP_MSUB:          nacc = tgt - p40;
            OP_AADD:          nacc = acc_a + acc_b;
            OP_ASUB:          nacc = tgt - oth;
            OP_ANEG:          nacc = 40'h00_0000_0000 - tgt;
            OP_LDA:           nacc = shd;
            OP_ADDW:          nacc = tgt + shd;
            OP_CLR:           nacc = 40'h00_0000_0000;
            default:          nacc = tgt;
        endcase
        // Convergent rounding only differs at an exact half
        if (!ctrl[CB_RDM] && oth[15:0] == 16'h8000)
            rinc = oth[16];
        else
            rinc = oth[15];
        rhi   = oth[31:16] + {15'h0000, rinc};
        wb_ok = (cmd.op == OP_MACC) || (cmd.op == OP_MSUB) ||
                (cmd.op == OP_MOVS) || (cmd.op == OP_CLR); // RULE_23
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_a <= 40'h00_0000_0000;
            acc_b <= 40'h00_0000_0000;
        end else if (go && is_dsp && cmd.op != OP_MOVS) begin
            if (cmd.acc_sel) acc_b <= nacc; // RULE_20
            else acc_a <= nacc;
        end else if (wr) begin
            if (paddr == A_AAL) acc_a[31:0] <= pwdata;
            if (paddr == A_AAH) acc_a[39:32] <= pwdata[7:0];
            if (paddr == A_ABL) acc_b[31:0] <= pwdata;
            if (paddr == A_ABH) acc_b[39:32] <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wback <= 16'h0000;
        else if (go && wb_ok && cmd.wb) wback <= rhi; // RULE_23
    end

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    logic [3:0]  dcnt;
    logic [15:0] drem, dquo, ddvs, nrem, nquo, vdvs;
    logic [17:0] trial;
    logic [31:0] dvd, vdvd;
    logic        dneg_q, dneg_r, dsg, dgo;

    always_comb begin
        dgo  = go && (cmd.op >= OP_DS16) && (cmd.op <= OP_DU32);
        dsg  = (cmd.op == OP_DS16) || (cmd.op == OP_DS32);
        if (cmd.op == OP_DS32 || cmd.op == OP_DU32)
            dvd = {opc, opa}; // RULE_09
        else
            dvd = {dsg ? {16{opa[15]}} : 16'h0000, opa}; // RULE_07
        vdvd  = (dsg && dvd[31]) ? 32'h0000_0000 - dvd : dvd;
        vdvs  = (dsg && opb[15]) ? 16'h0000 - opb : opb;
        trial = {1'b0, drem, dquo[15]} - {2'b00, ddvs};
        nrem  = trial[17] ? {drem[14:0], dquo[15]} : trial[15:0];
        nquo  = {dquo[14:0], !trial[17]};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dst    <= D_IDLE;
            dcnt   <= 4'h0;
            drem   <= 16'h0000;
            dquo   <= 16'h0000;
            ddvs   <= 16'h0000;
            dneg_q <= 1'b0;
            dneg_r <= 1'b0;
        end else if (dst == D_IDLE) begin
            if (dgo) begin
                dst    <= D_RUN;
                dcnt   <= 4'h0;
                drem   <= vdvd[31:16];
                dquo   <= vdvd[15:0];
                ddvs   <= vdvs;
                dneg_q <= dsg && (dvd[31] ^ opb[15]);
                dneg_r <= dsg && dvd[31];
            end
        end else begin
            drem <= nrem;
            dquo <= nquo;
            dcnt <= dcnt + 4'h1; // RULE_10
            if (dcnt == DIV_LAST) dst <= D_IDLE;
        end
    end

    // ----------------------------------------
    // Working result registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quo <= 16'h0000;
            rem <= 16'h0000;
        end else if (dst == D_RUN && dcnt == DIV_LAST) begin
            quo <= dneg_q ? 16'h0000 - nquo : nquo; // RULE_08 RULE_25
            rem <= dneg_r ? 16'h0000 - nrem : nrem;
        end else if (go && is_int) begin
            quo <= ares[15:0]; // RULE_05
        end else if (go && cmd.op >= OP_MSS && cmd.op <= OP_MUS) begin
            quo <= prod[15:0]; // RULE_19
            rem <= cmd.byte_mode ? 16'h0000 : prod[31:16];
        end else if (wr && !busy) begin
            if (paddr == A_QUO) quo <= pwdata[15:0];
            if (paddr == A_REM) rem <= pwdata[15:0];
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [31:0] h_dvd;
    logic [15:0] h_dvs;
    logic        h_u16;
    logic [4:0]  h_blen;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            h_dvd <= 32'h0000_0000;
            h_dvs <= 16'h0000;
            h_u16 <= 1'b0;
        end else if (dgo) begin
            h_dvd <= dvd;
            h_dvs <= opb;
            h_u16 <= (cmd.op == OP_DU16);
        end
    end

    // Busy run length; avoids a long repetition in the length check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) h_blen <= 5'h00;
        else h_blen <= busy ? h_blen + 5'h01 : 5'h00;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_div_go;
        dgo;
    endsequence
    sequence s_div_run;
        ##16 !busy && h_blen == 5'h10;
    endsequence
    property p_div_len;
        s_div_go |=> s_div_run;
    endproperty
    a_div_len: assert property (p_div_len) else $error("divide length wrong"); // RULE_10

    property p_div_hold;
        busy ##1 busy |-> $stable(quo) && $stable(rem);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("result moved early"); // RULE_25

    property p_div_val;
        $fell(busy) && h_u16 && h_dvs != 16'h0000 |->
            {16'h0000, quo} * {16'h0000, h_dvs} + {16'h0000, rem} == h_dvd && rem < h_dvs;
    endproperty
    a_div_val: assert property (p_div_val) else $error("divide result wrong"); // RULE_08

    property p_add;
        go && cmd.op == OP_ADD && !cmd.byte_mode |=> quo == 16'(opa + opb);
    endproperty
    a_add: assert property (p_add) else $error("add result wrong"); // RULE_01

    property p_zero;
        go && is_int |=> stat[SB_Z] == (quo == 16'h0000);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE_02

    property p_borrow;
        go && cmd.op == OP_SUB && !cmd.byte_mode |=> stat[SB_C] == (opa >= opb);
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow flag wrong"); // RULE_03

    property p_byte;
        go && cmd.op == OP_ADD && cmd.byte_mode |=>
            quo == {8'h00, 8'(opa[7:0] + opb[7:0])};
    endproperty
    a_byte: assert property (p_byte) else $error("byte add wrong"); // RULE_04

    property p_mul;
        go && cmd.op == OP_MUU && !cmd.byte_mode |=> {rem, quo} == opa * opb;
    endproperty
    a_mul: assert property (p_mul) else $error("multiply wrong"); // RULE_19

    property p_frac;
        go && cmd.op == OP_PRD && !cmd.acc_sel && !ctrl[CB_IF] && !ctrl[CB_USG] |=>
            acc_a[32:0] == {32'($signed(opa) * $signed(opb)), 1'b0} &&
            acc_a[39:33] == {7{acc_a[32]}};
    endproperty
    a_frac: assert property (p_frac) else $error("fractional product wrong"); // RULE_24

    property p_uint;
        go && cmd.op == OP_PRD && cmd.acc_sel && ctrl[CB_IF] && ctrl[CB_USG] |=>
            acc_b == {8'h00, 32'(opa * opb)};
    endproperty
    a_uint: assert property (p_uint) else $error("unsigned product wrong"); // RULE_16

    property p_neg;
        go && cmd.op == OP_ANEG && cmd.acc_sel |=>
            acc_b == 40'(40'h00_0000_0000 - $past(acc_b));
    endproperty
    a_neg: assert property (p_neg) else $error("negate wrong"); // RULE_13
endmodule : ad_alu_dsp

// *** tb/ad_apb_bfm.sv ***
// APB master model standing in for the instruction decoder.
// Assumes go is held until done is seen; one clock domain.
`timescale 1ns/1ps
module ad_apb_bfm (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Request side
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic [31:0]      rdata,
    output logic             err,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= 8'h00;
            pwdata  <= 32'h0;
            done    <= 1'b0;
            rdata   <= 32'h0;
            err     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (psel && penable && pready) begin
                // Released lines show no stale value
                psel    <= 1'b0;
                penable <= 1'b0;
                paddr   <= ~paddr;
                pwdata  <= ~pwdata;
                rdata   <= prdata;
                err     <= pslverr;
                done    <= 1'b1;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (go && !done) begin
                psel   <= 1'b1;
                pwrite <= wr;
                paddr  <= addr;
                pwdata <= wdata;
            end
        end
    end
endmodule : ad_apb_bfm

// *** tb/ad_alu_dsp_tb.sv ***
// Self-checking bench of the arithmetic datapath over APB.
// Assumes the register map and command word of ad_pkg.
`timescale 1ns/1ps
module ad_alu_dsp_tb;
    import ad_pkg::*;
    logic        clk, rst_n, go, wr, done, err;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  addr, paddr;
    logic [31:0] wdata, rdata, rd, pwdata, prdata, seed;
    int          num_errors, checks;
    ad_alu_dsp dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));
    ad_apb_bfm bfm (.clk(clk), .rst_n(rst_n), .go(go), .wr(wr), .addr(addr),
        .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    task automatic final_report;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait: a hung slave ends the run
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        go    <= 1'b1;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        while (!done && n < 20) begin
            @(posedge clk);
            n++;
        end
        go <= 1'b0;
        rd = rdata;
        if (n == 20) begin
            num_errors++;
            final_report();
        end
    endtask : bus
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rreg
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed & 32'hFFFF;
    endfunction : rnd
    function automatic logic [31:0] cmdw(input ad_op_t op, input logic bm, input logic sel);
        ad_cmd_t c;
        c = '0;
        c.op = op;
        c.byte_mode = bm;
        c.acc_sel = sel;
        return 32'(c);
    endfunction : cmdw
    // Returns {status, result}; carry reads as not-borrow on subtract
    function automatic logic [31:0] ex_alu(input logic sub, input logic bm,
                                           input logic [15:0] x, input logic [15:0] y);
        logic [16:0] s;
        logic [15:0] r;
        logic [4:0]  d;
        int          m;
        m = bm ? 7 : 15;
        if (bm) begin
            x = x & 16'h00FF;
            y = y & 16'h00FF;
        end
        s = sub ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
        d = sub ? {1'b0, x[3:0]} - {1'b0, y[3:0]} : {1'b0, x[3:0]} + {1'b0, y[3:0]};
        r = bm ? {8'h00, s[7:0]} : s[15:0];
        return {7'h00, sub ^ d[4], 4'h0, r[m], (x[m] ^ sub) == y[m] && r[m] != x[m],
                r == 16'h0000, sub ^ s[m + 1], r};
    endfunction : ex_alu
    function automatic longint ex_mul(input ad_op_t op, input logic bm,
                                      input logic [15:0] x, input logic [15:0] y);
        longint u, v;
        u = (op == OP_MSS || op == OP_MSL) ? longint'($signed(x)) : longint'(x);
        v = (op == OP_MSS || op == OP_MUS) ? longint'($signed(y)) : longint'(y);
        if (op == OP_MSL || op == OP_MUK) v = longint'(y[4:0]);
        if (bm) u = longint'(x[7:0]);
        if (bm) v = longint'(y[7:0]);
        return u * v;
    endfunction : ex_mul
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        logic [31:0] a, b, e;
        longint      p, q;
        int          n, prev;
        ad_op_t      op;
        rst_n = 1'b0;
        go = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        num_errors = 0;
        checks = 0;
        seed = 32'h62F2FF66;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rreg(A_CTRL, 32'h0);
        rreg(A_STAT, 32'h0);
        bus(1'b0, 8'h34, 32'h0);
        chk({31'h0, err}, 32'h1);
        bus(1'b1, A_CTRL, 32'h10F3);
        rreg(A_CTRL, 32'h10F3);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            a = (i < 2) ? 32'h7FFF * (1 - i) : rnd();
            b = (i < 2) ? 32'h1 - i : rnd();
            bus(1'b1, A_OPA, a);
            bus(1'b1, A_OPB, b);
            bus(1'b1, A_CMD, cmdw(i[0] ? OP_SUB : OP_ADD, i[2], 1'b0));
            e = ex_alu(i[0], i[2], a[15:0], b[15:0]);
            rreg(A_QUO, {16'h0, e[15:0]});
            rreg(A_STAT, {16'h0, e[31:16]});
        end
        $display("test integer unit done");
        for (int i = 0; i < 10; i++) begin
            op = ad_op_t'(5'h08 + 5'(i % 5));
            a = (i == 0) ? 32'h8000 : rnd();
            b = (i == 0) ? 32'h8000 : rnd();
            bus(1'b1, A_OPA, a);
            bus(1'b1, A_OPB, b);
            bus(1'b1, A_CMD, cmdw(op, i == 1, 1'b0));
            p = ex_mul(op, i == 1, a[15:0], b[15:0]);
            rreg(A_QUO, {16'h0, p[15:0]});
            rreg(A_REM, {16'h0, p[31:16]});
        end
        $display("test multiply done");
        for (int i = 0; i < 6; i++) begin
            a = rnd();
            b = (rnd() & 32'h7FFF) | 32'h1;
            e = rnd() % b;
            bus(1'b1, A_OPA, a);
            bus(1'b1, A_OPB, b);
            bus(1'b1, A_OPC, e);
            bus(1'b1, A_CMD, cmdw(ad_op_t'(5'h0D + 5'(i % 4)), 1'b0, 1'b0));
            n = 0;
            do begin
                bus(1'b0, A_STAT, 32'h0);
                n++;
            end while (rd[SB_BUSY] && n < 40);
            if (rd[SB_BUSY]) begin
                num_errors++;
                final_report();
            end
            if (i > 0) chk(32'(n), 32'(prev));
            prev = n;
            p = (i % 4 > 1) ? longint'({e[15:0], a[15:0]}) : longint'(a[15:0]);
            if (i % 4 == 0) p = longint'($signed(a[15:0]));
            q = p / longint'(b[15:0]);
            p = p % longint'(b[15:0]);
            rreg(A_QUO, {16'h0, q[15:0]});
            rreg(A_REM, {16'h0, p[15:0]});
        end
        $display("test divide done");
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 32'h8000 : rnd();
            b = (i == 0) ? 32'h8000 : rnd();
            bus(1'b1, A_CTRL, 32'(i[0]) | (32'(i == 3) << CB_USG));
            bus(1'b1, A_OPA, a);
            bus(1'b1, A_OPB, b);
            bus(1'b1, A_CMD, cmdw(OP_PRD, 1'b0, i[1]));
            p = longint'($signed(a[15:0])) * longint'($signed(b[15:0])) * (i[0] ? 1 : 2);
            if (i == 3) p = longint'(a[15:0]) * longint'(b[15:0]);
            rreg(i[1] ? A_ABL : A_AAL, p[31:0]);
            rreg(i[1] ? A_ABH : A_AAH, {24'h0, p[39:32]});
        end
        bus(1'b1, A_CMD, cmdw(OP_ANEG, 1'b0, 1'b1));
        p = -p;
        rreg(A_ABL, p[31:0]);
        rreg(A_ABH, {24'h0, p[39:32]});
        $display("test engine done");
        final_report();
    end
endmodule : ad_alu_dsp_tb
